// [shared/flash_host_pkg.sv]
// flash_host_pkg: command codes, bus widths and strobe timing for the flash bus host
// assumes a 250 MHz system clock; the flash itself has no clock
package flash_host_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned ADDR_W          = 18;
  localparam int unsigned DATA_W          = 16;
  localparam logic [7:0]  CMD_READ_ARRAY  = 8'hFF;
  localparam logic [7:0]  CMD_IDENTIFY    = 8'h90;
  localparam logic [7:0]  CMD_READ_STATUS = 8'h70;
  localparam logic [7:0]  CMD_CLEAR_STAT  = 8'h50;
  localparam logic [7:0]  CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0]  CMD_CONFIRM     = 8'hD0;
  localparam logic [7:0]  CMD_WRITE_SETUP = 8'h40;
  localparam logic [7:0]  CMD_WRITE_ALT   = 8'h10;
  localparam logic [7:0]  CMD_SUSPEND     = 8'hB0;
  localparam int unsigned READY_BIT       = 7;
  // strobe phase lengths, rounded up to whole cycles
  localparam int unsigned SETUP_NS        = 20;
  localparam int unsigned STROBE_NS       = 80;
  localparam int unsigned HOLD_NS         = 20;
  localparam int unsigned SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYC   = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  SETUP_CNT  = 8'(SETUP_CYC);
  localparam logic [7:0]  STROBE_CNT = 8'(STROBE_CYC);
  localparam logic [7:0]  HOLD_CNT   = 8'(HOLD_CYC);
  typedef enum logic [1:0] {OP_READ, OP_COMMAND, OP_WRITE} op_t;
endpackage : flash_host_pkg

// [logic/phase_timer.sv]
// phase_timer: down counter that pulses done when a loaded count expires
// assumes load and count come from logic on the same clock
`timescale 1ns/1ns
module phase_timer
  import flash_host_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       load_i,
  input  wire logic [7:0] count_i,
  output logic            done_o
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       done_d;
  logic       done_q;

  // reload wins over counting so a phase never ends early
  always_comb
  begin
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (load_i)
      cnt_d = count_i;
    else if (cnt_q != 8'h00)
    begin
      cnt_d  = cnt_q - 8'h01;
      done_d = (cnt_q == 8'h01);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_q  <= 8'h00;
      done_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done_o = done_q;
endmodule : phase_timer

// [logic/flash_bus_host.sv]
// flash_bus_host: drives the flash's chip select, output enable and write strobes
// assumes one user request at a time and the flash pins wired directly to the ports
//
// Contract
// - array read: write strobe high, select and enable low, data follows address
// - status latches on later falling strobe; toggle a strobe to refresh it
// - command: enable high, select and strobe low, code on low byte
// - array write needs program voltage and enable high, width per select; the host drives no program voltage pin
// - write setup code must come in the cycle just before array data
// - never issue reserved or unlisted codes
`timescale 1ns/1ns
module flash_bus_host
  import flash_host_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              req_i,
  input  wire op_t               op_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              word_mode_i,
  input  wire logic              byte_lsb_i,
  input  wire logic              boot_unlock_i,
  output logic                   busy_o,
  output logic                   done_o,
  output logic                   refused_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic                   engine_ready_o,
  output logic                   chip_sel_n_o,
  output logic                   out_en_n_o,
  output logic                   wr_en_n_o,
  output logic                   width_sel_o,
  output logic                   write_protect_o,
  output logic [ADDR_W-1:0]      addr_o,
  output logic [DATA_W-1:0]      dq_o,
  output logic [DATA_W-1:0]      dq_oe_n_o,
  input  wire logic [DATA_W-1:0] dq_i
);
  typedef enum {S_IDLE, S_SETUP, S_STROBE, S_HOLD} state_t;

  state_t              st_q, st_d;
  op_t                 op_q, op_d;
  logic                wsetup_q, wsetup_d;
  logic [DATA_W-1:0]   dq_s1_q, dq_s2_q;
  logic                cs_n_q, cs_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d;
  logic                done_q, done_d, ref_q, ref_d, byte_q, byte_d, wp_q, wp_d;
  logic [ADDR_W-1:0]   addr_q, addr_d;
  logic [DATA_W-1:0]   dout_q, dout_d, doe_n_q, doe_n_d, rdata_q, rdata_d;
  logic                rdy_q, rdy_d, busy_q, busy_d;
  logic                tload;
  logic [7:0]          tcount;
  logic                tdone;
  logic [7:0]          code;
  logic                legal;

  phase_timer u_timer (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .load_i    (tload),
    .count_i   (tcount),
    .done_o    (tdone)
  );

  // only listed codes go out; anything else is refused at the port
  assign code  = wdata_i[7:0];
  assign legal = (code == CMD_READ_ARRAY) || (code == CMD_IDENTIFY)
              || (code == CMD_READ_STATUS) || (code == CMD_CLEAR_STAT)
              || (code == CMD_ERASE_SETUP) || (code == CMD_CONFIRM)
              || (code == CMD_WRITE_SETUP) || (code == CMD_WRITE_ALT)
              || (code == CMD_SUSPEND);

  // data pins cross in through two flops before use
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
    end
    else
    begin
      dq_s1_q <= dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  // bus cycle sequencer: setup, strobe low, strobe high, hold
  always_comb
  begin
    st_d     = st_q;
    op_d     = op_q;
    wsetup_d = wsetup_q;
    cs_n_d   = cs_n_q;
    oe_n_d   = oe_n_q;
    we_n_d   = we_n_q;
    addr_d   = addr_q;
    dout_d   = dout_q;
    doe_n_d  = doe_n_q;
    byte_d   = byte_q;
    wp_d     = wp_q;
    rdata_d  = rdata_q;
    rdy_d    = rdy_q;
    done_d   = 1'b0;
    ref_d    = 1'b0;
    tload    = 1'b0;
    tcount   = SETUP_CNT;
    case (st_q)
      S_IDLE:
      begin
        if (req_i)
        begin
          // a data write with no setup just before it is refused
          if ((op_i == OP_COMMAND && !legal) || (op_i == OP_WRITE && !wsetup_q))
            ref_d = 1'b1;
          else
          begin
            op_d   = op_i;
            byte_d = word_mode_i;
            wp_d   = boot_unlock_i;
            addr_d = addr_i;
            cs_n_d = 1'b0;
            tload  = 1'b1;
            st_d   = S_SETUP;
            if (op_i == OP_READ)
              doe_n_d = 16'hFFFF;
            else
            begin
              doe_n_d = 16'h0000;
              if (op_i == OP_COMMAND)
              begin
                // code rides the low byte only, so lines 8 to 15 float in byte mode too
                dout_d  = {8'h00, code};
                doe_n_d = 16'hFF00;
              end
              else if (word_mode_i)
                dout_d = wdata_i;
              else
              begin
                // line 15 carries the low address bit, 8 to 14 float
                dout_d  = {byte_lsb_i, 7'h00, wdata_i[7:0]};
                doe_n_d = 16'h7F00;
              end
            end
            if (op_i == OP_READ && !word_mode_i)
            begin
              dout_d  = {byte_lsb_i, 15'h0000};
              doe_n_d = 16'h7FFF;
            end
          end
        end
      end
      S_SETUP:
      begin
        if (tdone)
        begin
          // strobe falls late so status latches fresh each cycle
          if (op_q == OP_READ)
            oe_n_d = 1'b0;
          else
            we_n_d = 1'b0;
          tload  = 1'b1;
          tcount = STROBE_CNT;
          st_d   = S_STROBE;
        end
      end
      S_STROBE:
      begin
        if (tdone)
        begin
          if (op_q == OP_READ)
          begin
            rdata_d = byte_q ? dq_s2_q : {8'h00, dq_s2_q[7:0]};
            rdy_d   = dq_s2_q[READY_BIT];
          end
          // write strobe rises first, so the flash latches here
          oe_n_d = 1'b1;
          we_n_d = 1'b1;
          tload  = 1'b1;
          tcount = HOLD_CNT;
          st_d   = S_HOLD;
        end
      end
      S_HOLD:
      begin
        if (tdone)
        begin
          cs_n_d  = 1'b1;
          doe_n_d = 16'hFFFF;
          done_d  = 1'b1;
          st_d    = S_IDLE;
          if (op_q == OP_COMMAND)
            wsetup_d = (dout_q[7:0] == CMD_WRITE_SETUP) || (dout_q[7:0] == CMD_WRITE_ALT);
          else
            wsetup_d = 1'b0;
        end
      end
      default:
        st_d = S_IDLE;
    endcase
    busy_d = (st_d != S_IDLE);
  end

  // all pins idle inactive; flash starts in array read after reset
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_q     <= S_IDLE;
      op_q     <= OP_READ;
      wsetup_q <= 1'b0;
      cs_n_q   <= 1'b1;
      oe_n_q   <= 1'b1;
      we_n_q   <= 1'b1;
      addr_q   <= '0;
      dout_q   <= 16'h0000;
      doe_n_q  <= 16'hFFFF;
      byte_q   <= 1'b1;
      wp_q     <= 1'b0;
      rdata_q  <= 16'h0000;
      rdy_q    <= 1'b0;
      done_q   <= 1'b0;
      ref_q    <= 1'b0;
      busy_q   <= 1'b0;
    end
    else
    begin
      st_q     <= st_d;
      op_q     <= op_d;
      wsetup_q <= wsetup_d;
      cs_n_q   <= cs_n_d;
      oe_n_q   <= oe_n_d;
      we_n_q   <= we_n_d;
      addr_q   <= addr_d;
      dout_q   <= dout_d;
      doe_n_q  <= doe_n_d;
      byte_q   <= byte_d;
      wp_q     <= wp_d;
      rdata_q  <= rdata_d;
      rdy_q    <= rdy_d;
      done_q   <= done_d;
      ref_q    <= ref_d;
      busy_q   <= busy_d;
    end
  end

  assign busy_o          = busy_q;
  assign done_o          = done_q;
  assign refused_o       = ref_q;
  assign rdata_o         = rdata_q;
  assign engine_ready_o  = rdy_q;
  assign chip_sel_n_o    = cs_n_q;
  assign out_en_n_o      = oe_n_q;
  assign wr_en_n_o       = we_n_q;
  assign width_sel_o     = byte_q;
  assign write_protect_o = wp_q;
  assign addr_o          = addr_q;
  assign dq_o            = dout_q;
  assign dq_oe_n_o       = doe_n_q;

  // write strobe never falls while output enable is low
  chk_strobe_excl: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !(!we_n_q && !oe_n_q)) else $error("write and output strobes low together");

  sequence seq_strobe_end;
    !we_n_q ##1 we_n_q;
  endsequence
  // select stays low past the rising write strobe
  chk_first_rise: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    seq_strobe_end |-> !cs_n_q) else $error("select rose with write strobe");

  // read keeps the low data byte released while output enable is low
  chk_read_float: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !oe_n_q |-> dq_oe_n_o[7:0] == 8'hFF) else $error("host drives low byte during read");

  // refused data write never starts a bus cycle
  chk_write_setup: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    ref_q |-> st_q == S_IDLE && cs_n_q) else $error("refused request started a cycle");

  // byte mode floats lines 8 to 14 while selected
  chk_byte_float: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (!cs_n_q && !byte_q) |-> dq_oe_n_o[14:8] == 7'h7F) else $error("lines 8-14 driven");

  // done pulses for one cycle only
  chk_done_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    done_q |-> ##1 !done_q) else $error("done longer than one cycle");

  // output enable stays low for at least 8 cycles once it falls
  chk_strobe_len: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $fell(oe_n_q) |-> !oe_n_q [*8]) else $error("output enable pulse too short");

  // unlock level is held for the whole selected cycle
  chk_unlock_held: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (!cs_n_q && $past(!cs_n_q)) |-> $stable(wp_q)) else $error("protect changed mid cycle");
endmodule : flash_bus_host

// [testbench/flash_model.sv]
// flash_model: behavioural flash device on the host strobes, 32-word array
// assumes the bench resolves the shared data lines; no clock, strobe edges only
`timescale 1ns/1ns
module flash_model
  import flash_host_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] PART_ID  = 8'h3C, // arbitrary value
  parameter logic [7:0] HI_MAKER = 8'h11, // arbitrary value
  parameter logic [7:0] HI_PART  = 8'h22  // arbitrary value
)
(
  input  wire logic              chip_sel_n_i,
  input  wire logic              out_en_n_i,
  input  wire logic              wr_en_n_i,
  input  wire logic              width_sel_i,
  input  wire logic              write_protect_i,
  input  wire logic              id_supervoltage_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] dq_i,
  output logic      [DATA_W-1:0] dq_o
);
  logic [15:0] mem [32];
  logic [1:0]  mode_q  = 2'h0; // array read from power-up
  logic        setup_q = 1'b0;
  logic        eset_q  = 1'b0;
  logic        susp_q  = 1'b0;
  logic [7:0]  sr_q    = 8'h80; // engine finishes at once, so always ready
  logic [7:0]  sr_lat  = 8'h80;
  logic [15:0] val;
  logic [15:0] last    = 16'h0000;
  logic [4:0]  a;
  assign a = addr_i[4:0];

  initial for (int i = 0; i < 32; i++) mem[i] = 16'hFFFF;

  // latch on the first rising select or write strobe with enable high
  always @(posedge chip_sel_n_i or posedge wr_en_n_i)
    if (out_en_n_i && !(chip_sel_n_i && wr_en_n_i))
    begin
      if (setup_q)
      begin
        setup_q = 1'b0;
        mode_q  = 2'h1;
        if (addr_i < 18'h00010 && !write_protect_i) sr_q[4] = 1'b1;
        else if (width_sel_i) mem[a] = mem[a] & dq_i;
        else if (dq_i[15]) mem[a][15:8] = mem[a][15:8] & dq_i[7:0];
        else mem[a][7:0] = mem[a][7:0] & dq_i[7:0];
      end
      else if (!susp_q || dq_i[7:0] inside {8'hFF, 8'h70, 8'hD0})
      begin
        case (dq_i[7:0]) // upper lines ignored
          8'hFF: mode_q = 2'h0;
          8'h90: mode_q = 2'h2;
          8'h70: mode_q = 2'h1;
          8'h50: sr_q[5:3] = 3'h0;
          8'h40, 8'h10: setup_q = 1'b1;
          8'hB0:
          begin
            susp_q = 1'b1;
            mode_q = 2'h1;
          end
          8'hD0:
          begin
            if (eset_q) for (int i = 16; i < 32; i++) mem[i] = 16'hFFFF;
            susp_q = 1'b0;
            mode_q = 2'h1;
          end
          default: ; // invalid codes leave the mode alone
        endcase
        eset_q = (dq_i[7:0] == 8'h20);
      end
    end

  // status frozen at the later falling select or enable
  always @(negedge chip_sel_n_i or negedge out_en_n_i)
    if (!chip_sel_n_i && !out_en_n_i) sr_lat = sr_q;

  // read path by mode
  always_comb
    case (id_supervoltage_i ? 2'h2 : mode_q) // forced id read, mode kept
      2'h2: val = addr_i[0] ? {HI_PART, PART_ID} : {HI_MAKER, MAKER_ID};
      2'h1: val = {8'h00, sr_lat}; // address ignored, upper low
      default: val = width_sel_i ? mem[a] : {8'h00, dq_i[15] ? mem[a][15:8] : mem[a][7:0]};
    endcase

  // released lines show the inverse of the last read, so stale data cannot pass
  always @(posedge out_en_n_i or posedge chip_sel_n_i) last = val;
  assign dq_o = (!chip_sel_n_i && !out_en_n_i && wr_en_n_i)
              ? {width_sel_i ? val[15:8] : ~last[15:8], val[7:0]}
              : ~last;
endmodule : flash_model

// [testbench/flash_bus_mode_and_command_decoder_test.sv]
// flash_bus_mode_and_command_decoder_test: self-checking bench for flash_bus_host
// assumes flash_model on the pins; driver queues notes, a monitor checks on done or refused
`timescale 1ns/1ns
module flash_bus_mode_and_command_decoder_test;
  import flash_host_pkg::*;
  localparam logic [7:0] MAKER_ID = 8'h5A; // arbitrary value
  localparam logic [7:0] PART_ID  = 8'h3C; // arbitrary value
  localparam logic [7:0] HI_MAKER = 8'h11; // arbitrary value
  localparam logic [7:0] HI_PART  = 8'h22; // arbitrary value
  logic              sys_clk_i = 0, rst_b_i = 0, req_i = 0, word_mode_i = 1;
  logic              byte_lsb_i = 0, boot_unlock_i = 0, id_hv = 0;
  op_t               op_i = OP_READ;
  logic [ADDR_W-1:0] addr_i = '0, addr_o, a;
  logic [DATA_W-1:0] wdata_i = '0, rdata_o, dq_o, dq_oe_n_o, dev_dq, dq_i, d;
  logic              busy_o, done_o, refused_o, engine_ready_o, chip_sel_n_o;
  logic              out_en_n_o, wr_en_n_o, width_sel_o, write_protect_o;
  logic [17:0]       exp_q[$]; // {refused, compare data, data}
  logic [17:0]       e;
  logic [15:0]       lfsr = 16'h43D1;
  int                n_mismatch = 0, cmp_count = 0;

  // host wins on every line it enables
  assign dq_i = (~dq_oe_n_o & dq_o) | (dq_oe_n_o & dev_dq);

  flash_bus_host i_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .req_i(req_i), .op_i(op_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .word_mode_i(word_mode_i), .byte_lsb_i(byte_lsb_i),
    .boot_unlock_i(boot_unlock_i), .busy_o(busy_o), .done_o(done_o), .refused_o(refused_o),
    .rdata_o(rdata_o), .engine_ready_o(engine_ready_o), .chip_sel_n_o(chip_sel_n_o),
    .out_en_n_o(out_en_n_o), .wr_en_n_o(wr_en_n_o), .width_sel_o(width_sel_o),
    .write_protect_o(write_protect_o), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o),
    .dq_i(dq_i));
  flash_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID), .HI_MAKER(HI_MAKER), .HI_PART(HI_PART))
    i_flash (.chip_sel_n_i(chip_sel_n_o), .out_en_n_i(out_en_n_o), .wr_en_n_i(wr_en_n_o),
             .width_sel_i(width_sel_o), .write_protect_i(write_protect_o), .addr_i(addr_o),
             .id_supervoltage_i(id_hv), .dq_i(dq_i), .dq_o(dev_dq));

  initial forever #2 sys_clk_i = ~sys_clk_i;

  function automatic logic [15:0] next_rand(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : next_rand

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // one request, held for its taking edge, then a bounded wait for its note to retire
  task automatic do_op(input op_t op, input logic [ADDR_W-1:0] ad, input logic [15:0] wd,
                       input logic [17:0] note);
    int k;
    exp_q.push_back(note);
    req_i   = 1'b1;
    op_i    = op;
    addr_i  = ad;
    wdata_i = wd;
    @(posedge sys_clk_i);
    #1 req_i = 1'b0;
    check("busy", {15'h0, busy_o}, {15'h0, ~note[17]});
    k = 0;
    while (exp_q.size() > 0 && k < 300)
    begin
      @(posedge sys_clk_i);
      k++;
    end
    #1;
    if (k == 300)
    begin
      n_mismatch++;
      report_and_stop;
    end
  endtask : do_op

  task automatic cmd(input logic [7:0] c);
    do_op(OP_COMMAND, a, {8'hA5, c}, 18'h00000); // junk upper byte must not matter
  endtask : cmd

  task automatic rd(input logic [ADDR_W-1:0] ad, input logic [15:0] x);
    do_op(OP_READ, ad, 16'h0000, {2'b01, x});
  endtask : rd

  task automatic wr(input logic [ADDR_W-1:0] ad, input logic [15:0] x);
    do_op(OP_WRITE, ad, x, 18'h00000);
  endtask : wr

  // monitor samples mid-cycle so it never races the driver
  always @(negedge sys_clk_i)
    if (done_o === 1'b1 || refused_o === 1'b1)
    begin
      if (exp_q.size() == 0) e = 18'h3FFFF;
      else e = exp_q.pop_front();
      check("refused", {15'h0, refused_o}, {15'h0, e[17]});
      if (e[16])
      begin
        check("rdata", rdata_o, e[15:0]);
        check("ready", {15'h0, engine_ready_o}, {15'h0, e[7]});
      end
    end

  initial
  begin
    repeat (4) @(posedge sys_clk_i);
    #1 rst_b_i = 1'b1;
    lfsr = next_rand(lfsr);
    a = 18'h00010 | 18'(lfsr[3:0]);
    d = next_rand(lfsr);
    rd(a, 16'hFFFF);
    do_op(OP_WRITE, a, d, 18'h20000);
    cmd(8'h40);
    wr(a, d);
    rd(18'h00000, 16'h0080);
    cmd(8'hFF);
    rd(a, d);
    cmd(8'h10);
    wr(a, 16'hFF0F);
    d = d & 16'hFF0F;
    cmd(8'hFF);
    rd(a, d);
    cmd(8'h40);
    wr(18'h00002, 16'h0000);
    rd(18'h00000, 16'h0090);
    cmd(8'h50);
    rd(18'h00000, 16'h0080);
    cmd(8'hFF);
    rd(18'h00002, 16'hFFFF);
    boot_unlock_i = 1'b1;
    cmd(8'h40);
    wr(18'h00002, 16'h0000);
    boot_unlock_i = 1'b0;
    cmd(8'hFF);
    rd(18'h00002, 16'h0000);
    cmd(8'h90);
    rd(18'h00000, {HI_MAKER, MAKER_ID});
    rd(18'h00001, {HI_PART, PART_ID});
    word_mode_i = 1'b0;
    rd(18'h00001, {8'h00, PART_ID});
    cmd(8'h70);
    rd(a, 16'h0080);
    cmd(8'hFF);
    byte_lsb_i = 1'b1;
    rd(a, {8'h00, d[15:8]});
    byte_lsb_i = 1'b0;
    rd(a, {8'h00, d[7:0]});
    word_mode_i = 1'b1;
    do_op(OP_COMMAND, a, 16'h0000, 18'h20000);
    rd(a, d);
    cmd(8'h20);
    cmd(8'hD0);
    rd(18'h00000, 16'h0080);
    cmd(8'hFF);
    rd(a, 16'hFFFF);
    rd(18'h00002, 16'h0000);
    cmd(8'hB0);
    cmd(8'h90);
    rd(a, 16'h0080);
    cmd(8'hD0);
    cmd(8'hFF);
    rd(a, 16'hFFFF);
    id_hv = 1'b1;
    rd(18'h00000, {HI_MAKER, MAKER_ID});
    id_hv = 1'b0;
    rd(a, 16'hFFFF);
    report_and_stop;
  end
endmodule : flash_bus_mode_and_command_decoder_test
